// file: rac_pkg.sv
// Constants and register map of the alarm, calibration and pulse-output block
package rac_pkg;

    // ==========================================================
    // Bus and register map
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam logic [7:0]  OFF_ALARM_HIGH  = 8'h20;
    localparam logic [7:0]  OFF_ALARM_LOW   = 8'h24;
    localparam logic [7:0]  OFF_CAL_OUT     = 8'h2C;
    localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h30;
    localparam logic [7:0]  OFF_IRQ_CLEAR   = 8'h34;
    localparam logic [7:0]  OFF_IRQ_ENABLE  = 8'h38;
    localparam logic [7:0]  OFF_TIME_COUNT  = 8'h3C;

    // ==========================================================
    // Field layout
    localparam int          HALF_W          = 16;
    localparam int          CAL_W           = 7;
    localparam int          CCO_BIT         = 7;
    localparam int          ENA_BIT         = 8;
    localparam int          SEL_BIT         = 9;
    localparam int          CAL_REG_W       = 10;
    localparam int          EVT_W           = 2;
    localparam int          EVT_ALARM       = 0;
    localparam int          EVT_SECOND      = 1;

    // ==========================================================
    // Reset values
    localparam logic [15:0] ALARM_HALF_RST  = 16'hFFFF;
    localparam logic [9:0]  CAL_REG_RST     = 10'h000;
    localparam logic [31:0] COUNT_RST       = 32'h0000_0000;
    localparam logic [1:0]  EVT_RST         = 2'h0;

    // ==========================================================
    // Calibration window and output divider
    localparam int          WIN_W           = 20;
    localparam int          DIV_W           = 6;
    localparam logic [19:0] WIN_RST         = 20'h0_0000;
    localparam logic [5:0]  DIV_RST         = 6'h00;

endpackage : rac_pkg

// file: rac_alarm_cal.sv
// Alarm compare, calibration pulse dropping and RTC pin output behind APB
`timescale 1ns/1ps
`default_nettype none

module rac_alarm_cal
    import rac_pkg::*;
(
    // Clock and resets
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                bd_resetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [DATA_W-1:0]   pwdata,
    output var  logic [DATA_W-1:0]   prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Alarm unlock flag and timebase inputs
    input  wire logic                config_unlock_flag,
    input  wire logic                tick_clock,
    input  wire logic                rtc_clk_en,
    // Outputs
    output var  logic                rtc_clk_cal_en,
    output var  logic                alarm_pulse,
    output var  logic                rtc_out,
    output logic                     irq
);

    // ==========================================================
    // Address decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    logic [HALF_W-1:0]      alarm_high_word;
    logic [HALF_W-1:0]      alarm_low_word;
    logic [CAL_REG_W-1:0]   calibration_and_pulse_output;
    logic [EVT_W-1:0]       irq_status;
    logic [EVT_W-1:0]       irq_enable;
    logic [DATA_W-1:0]      time_count;
    logic [WIN_W-1:0]       win_cnt;
    logic [DIV_W-1:0]       div_cnt;

    wire                    access    = psel & penable;
    wire                    wr_en     = access & pwrite;
    wire                    setup_rd  = psel & ~penable & ~pwrite;
    wire                    sel_hi    = hit(paddr, OFF_ALARM_HIGH);
    wire                    sel_lo    = hit(paddr, OFF_ALARM_LOW);
    wire                    sel_cal   = hit(paddr, OFF_CAL_OUT);
    wire                    sel_st    = hit(paddr, OFF_IRQ_STATUS);
    wire                    sel_clr   = hit(paddr, OFF_IRQ_CLEAR);
    wire                    sel_en    = hit(paddr, OFF_IRQ_ENABLE);
    wire                    sel_cnt   = hit(paddr, OFF_TIME_COUNT);
    wire                    addr_ok   = sel_hi | sel_lo | sel_cal | sel_st | sel_clr
                                        | sel_en | sel_cnt;

    // Locked alarm writes complete normally but store nothing
    wire                    wr_hi     = wr_en & sel_hi & config_unlock_flag;
    wire                    wr_lo     = wr_en & sel_lo & config_unlock_flag;
    wire                    wr_cal    = wr_en & sel_cal;
    wire                    wr_clr    = wr_en & sel_clr;
    wire                    wr_en_reg = wr_en & sel_en;

    assign pready  = 1'b1;
    assign pslverr = access & ~addr_ok;

    // ==========================================================
    // Read data, captured in the setup cycle for zero wait states
    wire [DATA_W-1:0]       alarm_value = {alarm_high_word, alarm_low_word};
    wire [DATA_W-1:0]       rd_mux =
        sel_hi  ? {{(DATA_W-HALF_W){1'b0}}, alarm_high_word} :
        sel_lo  ? {{(DATA_W-HALF_W){1'b0}}, alarm_low_word} :
        sel_cal ? {{(DATA_W-CAL_REG_W){1'b0}}, calibration_and_pulse_output} :
        sel_st  ? {{(DATA_W-EVT_W){1'b0}}, irq_status} :
        sel_en  ? {{(DATA_W-EVT_W){1'b0}}, irq_enable} :
        sel_cnt ? time_count :
        {DATA_W{1'b0}};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= {DATA_W{1'b0}};
        else if (setup_rd)
            prdata <= rd_mux;
    end

    // ==========================================================
    // Alarm halves, all ones out of reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alarm_high_word <= ALARM_HALF_RST;
            alarm_low_word  <= ALARM_HALF_RST;
        end
        else
        begin
            if (wr_hi)
                alarm_high_word <= pwdata[HALF_W-1:0];
            if (wr_lo)
                alarm_low_word  <= pwdata[HALF_W-1:0];
        end
    end

    // ==========================================================
    // Calibration register lives on the backup-domain reset only
    always_ff @(posedge pclk or negedge bd_resetn)
    begin
        if (!bd_resetn)
            calibration_and_pulse_output <= CAL_REG_RST;
        else if (wr_cal)
            calibration_and_pulse_output <= pwdata[CAL_REG_W-1:0];
    end

    wire [CAL_W-1:0]        cal_value           = calibration_and_pulse_output[CAL_W-1:0];
    wire                    cal_clock_output    = calibration_and_pulse_output[CCO_BIT];
    wire                    pulse_output_enable = calibration_and_pulse_output[ENA_BIT];
    wire                    pulse_output_select = calibration_and_pulse_output[SEL_BIT];

    // ==========================================================
    // Time counter and alarm compare
    wire [DATA_W-1:0]       next_time_count = time_count + 32'h0000_0001;
    wire                    match           = tick_clock & (next_time_count == alarm_value);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            time_count  <= COUNT_RST;
            alarm_pulse <= 1'b0;
        end
        else
        begin
            if (tick_clock)
                time_count <= next_time_count;
            alarm_pulse <= match;
        end
    end

    // ==========================================================
    // Calibration: the first cal_value pulses of each window are swallowed
    // Window counts raw pulses, so the drop count is exact per 2^20
    wire                    drop_pulse = (win_cnt < {{(WIN_W-CAL_W){1'b0}}, cal_value});

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            win_cnt        <= WIN_RST;
            rtc_clk_cal_en <= 1'b0;
        end
        else
        begin
            if (rtc_clk_en)
                win_cnt <= win_cnt + 20'h0_0001;
            rtc_clk_cal_en <= rtc_clk_en & ~drop_pulse;
        end
    end

    // Divide-by-64 of the calibrated clock, bit 5 is a 50 percent square wave
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt <= DIV_RST;
        else if (rtc_clk_cal_en)
            div_cnt <= div_cnt + 6'h01;
    end

    // ==========================================================
    // Pin selection; pulse output takes priority over clock output
    wire                    pulse_src = pulse_output_select ? tick_clock : alarm_pulse;
    wire                    next_rtc_out =
        pulse_output_enable ? pulse_src :
        cal_clock_output    ? div_cnt[DIV_W-1] :
        1'b0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rtc_out <= 1'b0;
        else
            rtc_out <= next_rtc_out;
    end

    // ==========================================================
    // Interrupt status: set wins over a clear in the same cycle
    wire [EVT_W-1:0]        evt_set = {tick_clock, alarm_pulse};
    wire [EVT_W-1:0]        evt_clr = wr_clr ? pwdata[EVT_W-1:0] : EVT_RST;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status <= EVT_RST;
            irq_enable <= EVT_RST;
        end
        else
        begin
            irq_status <= (irq_status & ~evt_clr) | evt_set;
            if (wr_en_reg)
                irq_enable <= pwdata[EVT_W-1:0];
        end
    end

    assign irq = |(irq_status & irq_enable);

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_alarm_match;
        tick_clock && (time_count + 32'h0000_0001 == alarm_value)
            |=> alarm_pulse ##1 irq_status[EVT_ALARM];
    endproperty
    a_alarm_match: assert property (p_alarm_match) else $error("alarm match missed");

    property p_no_false_alarm;
        alarm_pulse |-> $past(tick_clock) && time_count == alarm_value;
    endproperty
    a_no_false_alarm: assert property (p_no_false_alarm) else $error("spurious alarm");

    property p_lock_high;
        psel && penable && pwrite && sel_hi && !config_unlock_flag |=> $stable(alarm_high_word);
    endproperty
    a_lock_high: assert property (p_lock_high) else $error("locked high write stored");

    property p_unlock_low;
        psel && penable && pwrite && sel_lo && config_unlock_flag
            |=> alarm_low_word == $past(pwdata[HALF_W-1:0]);
    endproperty
    a_unlock_low: assert property (p_unlock_low) else $error("low alarm write lost");

    property p_pulse_alarm;
        pulse_output_enable && !pulse_output_select |=> rtc_out == $past(alarm_pulse);
    endproperty
    a_pulse_alarm: assert property (p_pulse_alarm) else $error("alarm pulse not on pin");

    property p_pulse_second;
        pulse_output_enable && pulse_output_select |=> rtc_out == $past(tick_clock);
    endproperty
    a_pulse_second: assert property (p_pulse_second) else $error("second pulse not on pin");

    property p_div64;
        !pulse_output_enable && cal_clock_output |=> rtc_out == $past(div_cnt[DIV_W-1]);
    endproperty
    a_div64: assert property (p_div64) else $error("divided clock not on pin");

    property p_idle_pin;
        !pulse_output_enable && !cal_clock_output |=> !rtc_out;
    endproperty
    a_idle_pin: assert property (p_idle_pin) else $error("pin not idle");

    property p_cal_drop;
        rtc_clk_en && (win_cnt < {{(WIN_W-CAL_W){1'b0}}, cal_value}) |=> !rtc_clk_cal_en;
    endproperty
    a_cal_drop: assert property (p_cal_drop) else $error("pulse not dropped");

    property p_cal_pass;
        rtc_clk_en && !(win_cnt < {{(WIN_W-CAL_W){1'b0}}, cal_value}) |=> rtc_clk_cal_en;
    endproperty
    a_cal_pass: assert property (p_cal_pass) else $error("pulse wrongly dropped");

    property p_alarm_reset;
        !$past(presetn) |-> alarm_value == {ALARM_HALF_RST, ALARM_HALF_RST};
    endproperty
    a_alarm_reset: assert property (p_alarm_reset) else $error("alarm reset not all ones");

    property p_cal_keep;
        !$past(presetn) && $past(bd_resetn) && bd_resetn
            |-> calibration_and_pulse_output == $past(calibration_and_pulse_output);
    endproperty
    a_cal_keep: assert property (p_cal_keep) else $error("bus reset hit calibration");

    property p_count_step;
        tick_clock |=> time_count == $past(time_count) + 32'h0000_0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not advance");

    property p_count_hold;
        !tick_clock |=> $stable(time_count);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("counter moved without tick");

    // Sticky until software clears it; a clear loses against a new alarm
    property p_alarm_sticky;
        irq_status[EVT_ALARM] && !(wr_clr && pwdata[EVT_ALARM])
            |=> irq_status[EVT_ALARM];
    endproperty
    a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm flag lost");

    c_alarm_irq: cover property (alarm_pulse && irq_enable[EVT_ALARM] ##1 irq);
    c_locked_wr: cover property (psel && penable && pwrite && sel_hi && !config_unlock_flag);
    c_dropped:   cover property (rtc_clk_en && drop_pulse && cal_value != 7'h00);
    c_div_out:   cover property (!pulse_output_enable && cal_clock_output ##1 $rose(rtc_out));
    c_sec_out:   cover property (pulse_output_enable && pulse_output_select && tick_clock ##1 rtc_out);

endmodule : rac_alarm_cal

`default_nettype wire

// file: rac_alarm_cal_test.sv
// Self-checking testbench of the alarm, calibration and pulse-output block
`timescale 1ns/1ps
`default_nettype none

module rac_alarm_cal_test
    import rac_pkg::*;
;
    logic              pclk               = 1'b0;
    logic              presetn            = 1'b0;
    logic              bd_resetn          = 1'b0;
    logic              psel               = 1'b0;
    logic              penable            = 1'b0;
    logic              pwrite             = 1'b0;
    logic [ADDR_W-1:0] paddr              = '0;
    logic [DATA_W-1:0] pwdata             = '0;
    logic              config_unlock_flag = 1'b0;
    logic              tick_clock         = 1'b0;
    logic              rtc_clk_en         = 1'b0;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              rtc_clk_cal_en;
    logic              alarm_pulse;
    logic              rtc_out;
    logic              irq;
    logic [31:0]       rd;
    logic              err;
    logic              last_out           = 1'b0;
    int                n_errors           = 0;
    int                cmp_count          = 0;
    int                cyc                = 0;
    int                n_cal              = 0;
    int                n_rise             = 0;
    int                n_alarm            = 0;
    int                base;
    int                base2;

    rac_alarm_cal dut_u (
        .pclk(pclk), .presetn(presetn), .bd_resetn(bd_resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .config_unlock_flag(config_unlock_flag), .tick_clock(tick_clock),
        .rtc_clk_en(rtc_clk_en), .rtc_clk_cal_en(rtc_clk_cal_en),
        .alarm_pulse(alarm_pulse), .rtc_out(rtc_out), .irq(irq)
    );

    always #5 pclk = ~pclk;

    // ==========================================================
    // Event counters and hang guard
    always @(posedge pclk)
    begin
        cyc = cyc + 1;
        if (rtc_clk_cal_en === 1'b1) n_cal = n_cal + 1;
        if (alarm_pulse === 1'b1) n_alarm = n_alarm + 1;
        if (rtc_out === 1'b1 && last_out !== 1'b1) n_rise = n_rise + 1;
        last_out = rtc_out;
        if (cyc == 4000)
        begin
            n_errors = n_errors + 1;
            $display("ERROR %0t: run did not finish in time", $time);
            results();
        end
    end

    // ==========================================================
    // Bus and stimulus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rdchk

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            tick_clock <= 1'b1;
            @(posedge pclk);
            tick_clock <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask : ticks

    // Raw clock pulses on every cycle, then a short settle
    task automatic raw_clk(input int n);
        @(posedge pclk);
        rtc_clk_en <= 1'b1;
        repeat (n) @(posedge pclk);
        rtc_clk_en <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : raw_clk

    task automatic results();
        if (n_errors == 0 && cmp_count > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn   <= 1'b1;
        bd_resetn <= 1'b1;
        rdchk(OFF_ALARM_HIGH, 32'h0000_FFFF);
        rdchk(OFF_ALARM_LOW, 32'h0000_FFFF);
        rdchk(OFF_CAL_OUT, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        // Window starts at zero, so the first 5 raw pulses are dropped
        apb(1'b1, OFF_CAL_OUT, 32'h0000_0085);
        base = n_cal;
        raw_clk(20);
        chk(32'(n_cal - base), 32'h0000_000F);
        base = n_rise;
        raw_clk(256);
        chk(32'(n_rise - base), 32'h0000_0004);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(OFF_CAL_OUT, 32'h0000_0085);
        apb(1'b1, OFF_CAL_OUT, 32'h0000_0300);
        base = n_rise;
        ticks(1);
        chk(32'(n_rise - base), 32'h0000_0001);
        apb(1'b1, OFF_CAL_OUT, 32'h0000_0100);
        base = n_rise;
        ticks(1);
        chk(32'(n_rise - base), 32'h0000_0000);
        apb(1'b1, OFF_ALARM_LOW, 32'h0000_1234);
        rdchk(OFF_ALARM_LOW, 32'h0000_FFFF);
        apb(1'b1, OFF_ALARM_HIGH, 32'h0000_1234);
        rdchk(OFF_ALARM_HIGH, 32'h0000_FFFF);
        config_unlock_flag <= 1'b1;
        apb(1'b1, OFF_ALARM_HIGH, 32'h0000_0000);
        apb(1'b1, OFF_ALARM_LOW, 32'h0000_0005);
        rdchk(OFF_ALARM_HIGH, 32'h0000_0000);
        apb(1'b1, OFF_IRQ_ENABLE, 32'h0000_0001);
        base = n_alarm;
        base2 = n_rise;
        ticks(3);
        chk(32'(n_alarm - base), 32'h0000_0001);
        chk(32'(n_rise - base2), 32'h0000_0001);
        rdchk(OFF_TIME_COUNT, 32'h0000_0005);
        rdchk(OFF_IRQ_STATUS, 32'h0000_0003);
        chk({31'h0, irq}, 32'h0000_0001);
        // Second event stays masked after the alarm bit is cleared
        apb(1'b1, OFF_IRQ_CLEAR, 32'h0000_0001);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0000_0000);
        rdchk(OFF_IRQ_STATUS, 32'h0000_0002);
        apb(1'b1, OFF_IRQ_ENABLE, 32'h0000_0002);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0000_0001);
        @(posedge pclk);
        bd_resetn <= 1'b0;
        @(posedge pclk);
        bd_resetn <= 1'b1;
        rdchk(OFF_CAL_OUT, 32'h0000_0000);
        rdchk(OFF_ALARM_LOW, 32'h0000_0005);
        base = n_rise;
        ticks(2);
        chk(32'(n_rise - base), 32'h0000_0000);
        results();
    end

endmodule : rac_alarm_cal_test

`default_nettype wire
